// ### logic/sbw_pkg.sv
// What this block does
// - Timed wake-up and cyclic-sense wake-up never run together.
// - In Stop, chip-select rising edge wakes silently, with no interrupt or status.
// - Bus wake needs dominant longer than filter time, then a recessive return.
// - In Stop, filtered external reset wakes to Normal Request or Normal by strap.
// - Sleep wakes only from wake input, cyclic sense, timed wake or bus wake.
// - Watchdog runs only in Normal; a mode write with the Normal code services it.
// - Service in first half of the period resets the controller like overflow.
// - Grounded strap disables watchdog and Normal Request, sets disabled flag, sampled in Reset.
// - Strap with no resistor and no ground uses the internal 150ms base and flags it.
// - Watchdog base passes a prescaler chosen by the timing control field.
// - Normal Request times out after 150ms into Reset, then back to Normal Request.
// - Each switch follows its enable, gated by the pwm pin when pwm select is set.
// - Each switch reports open load and current limit flags.
// - Over-temperature turns both switches off, latches interrupt, sets all switch flags.
// - After thermal shutdown switches stay off until a control write with heat gone.
// - Enabled overvoltage shuts switches off until a control write after it clears.
// - Slew select picks 10.4k, 20k or fast; reset default is 20k.
// - Cleared pull-up enable drops bus pull-up in low power, picks alternate threshold.
// - Bus driver over-current keeps transmitter on, sets flag, interrupts when masked in.
// - Bus driver over-temperature disables transmitter, sets flag, interrupts when masked in.
// - Transmitter returns by itself once heat is gone and transmit data is high.
// - Interrupt line stays low until a status read acknowledges it, the source's mask bit is cleared, or the mode enters Sleep or Reset.
package sbw_pkg;

  localparam int CLK_MHZ = 100;

  // Timing figures in their own units and derived cycle counts.
  localparam int WD_INT_TIME_MS = 150;
  localparam int WD_INT_CYC     = WD_INT_TIME_MS * 1000 * CLK_MHZ;
  localparam int NREQ_TIME_MS   = 150;
  localparam int NREQ_CYC       = NREQ_TIME_MS * 1000 * CLK_MHZ;
  localparam int WD_EXT_TIME_MS = 100;
  localparam int WD_EXT_CYC     = WD_EXT_TIME_MS * 1000 * CLK_MHZ;
  localparam int RST_PULSE_US   = 1000;
  localparam int RST_PULSE_CYC  = RST_PULSE_US * CLK_MHZ;
  localparam int BUS_WAKE_US    = 100;
  localparam int BUS_WAKE_CYC   = BUS_WAKE_US * CLK_MHZ;
  localparam int LP_BASE_US     = 10000;
  localparam int LP_BASE_CYC    = LP_BASE_US * CLK_MHZ;
  localparam int RSTF_TIME_NS   = 1000;
  localparam logic [7:0] RSTF_CYC = 8'(RSTF_TIME_NS / (1000 / CLK_MHZ));

  // Mode select field codes.
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_STOP   = 2'h1;
  localparam logic [1:0] CMD_SLEEP  = 2'h2;

  // Slew select codes.
  localparam logic [1:0] SLEW_20K   = 2'h0;
  localparam logic [1:0] SLEW_10K4  = 2'h1;
  localparam logic [1:0] SLEW_FAST  = 2'h2;

  // Positions in the synchronised pin vector.
  localparam int NP       = 16;
  localparam int P_CS     = 0;
  localparam int P_XRST   = 1;
  localparam int P_WAKE   = 2;
  localparam int P_PWM    = 3;
  localparam int P_TXD    = 4;
  localparam int P_GND    = 5;
  localparam int P_RES    = 6;
  localparam int P_HSOT   = 7;
  localparam int P_OV     = 8;
  localparam int P_LOC    = 9;
  localparam int P_LOT    = 10;
  localparam int P_BUSDOM = 11;
  localparam int P_OL     = 12;
  localparam int P_CL     = 14;
  // Resting pin levels: chip select, external reset and transmit data idle high.
  localparam logic [NP-1:0] PIN_IDLE = 16'h0013;

  typedef enum logic [4:0] {
    SBW_RESET  = 5'h01,
    SBW_NREQ   = 5'h02,
    SBW_NORMAL = 5'h04,
    SBW_STOP   = 5'h08,
    SBW_SLEEP  = 5'h10
  } sbw_mode_e;

  function automatic logic [31:0] sbw_shift(input logic [31:0] base, input logic [2:0] sel);
    return base << sel;
  endfunction : sbw_shift

endpackage : sbw_pkg

// ### logic/sbw_wake_if.sv
`timescale 1ns/1ns
interface sbw_wake_if;
  logic en;
  logic bus_dom;
  logic wake;
  modport filt (input en, input bus_dom, output wake);
  modport ctl (output en, output bus_dom, input wake);
endinterface : sbw_wake_if

// ### logic/sbw_bus_wake.sv
`timescale 1ns/1ns
module sbw_bus_wake #(
  parameter int FILT_CYC = sbw_pkg::BUS_WAKE_CYC
) (
  input wire logic    clk,
  input wire logic    sys_rst,
  sbw_wake_if.filt    wk
);
  import sbw_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        armed;
    logic        wake;
  } sbw_bw_s;

  sbw_bw_s s_q, s_d;

  // ****************************************************************
  // Dominant pulse filter.
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.wake = 1'b0;
    if (!wk.en) begin
      s_d.cnt   = 32'h0;
      s_d.armed = 1'b0;
    end else if (wk.bus_dom) begin
      if (s_q.cnt >= 32'(FILT_CYC)) begin
        s_d.armed = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end else begin
      s_d.wake  = s_q.armed;
      s_d.armed = 1'b0;
      s_d.cnt   = 32'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wk.wake = s_q.wake;

endmodule : sbw_bus_wake

// ### logic/sbw_ctrl.sv
`timescale 1ns/1ns
module sbw_ctrl #(
  parameter int WD_INT_CYC   = sbw_pkg::WD_INT_CYC,
  parameter int WD_EXT_CYC   = sbw_pkg::WD_EXT_CYC,
  parameter int NREQ_CYC     = sbw_pkg::NREQ_CYC,
  parameter int RST_CYC      = sbw_pkg::RST_PULSE_CYC,
  parameter int BUS_WAKE_CYC = sbw_pkg::BUS_WAKE_CYC,
  parameter int LP_BASE_CYC  = sbw_pkg::LP_BASE_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cs_n,
  input  wire logic       ext_rst_n,
  input  wire logic       wake_input_pin,
  input  wire logic       direct_pwm_input,
  input  wire logic       txd,
  input  wire logic       watchdog_config_pin_gnd,
  input  wire logic       watchdog_config_pin_res,
  input  wire logic       hs_overtemp,
  input  wire logic       supply_overvoltage,
  input  wire logic       lin_overcurrent,
  input  wire logic       lin_overtemp,
  input  wire logic       lin_bus_dominant,
  input  wire logic [1:0] hs_open_load,
  input  wire logic [1:0] hs_current_limit,
  input  wire logic       mode_wr,
  input  wire logic [1:0] mode_select_field,
  input  wire logic       hs_ctrl_wr,
  input  wire logic [1:0] high_side_enable_bit,
  input  wire logic [1:0] switch_pwm_select,
  input  wire logic       timer_function_select,
  input  wire logic [2:0] low_power_period_field,
  input  wire logic [2:0] wd_prescale,
  input  wire logic       wake_input_enable,
  input  wire logic       overvoltage_shutdown_enable,
  input  wire logic       lin_pullup_enable,
  input  wire logic [1:0] lin_slew_select,
  input  wire logic       high_side_irq_mask,
  input  wire logic       lin_irq_mask,
  input  wire logic       status_read_ack,
  output logic [4:0]      mode_state,
  output logic            mcu_rst_n,
  output logic [1:0]      hs_on,
  output logic [1:0]      switch_open_load_flag,
  output logic [1:0]      switch_current_limit_flag,
  output logic            hs_irq_source,
  output logic            watchdog_disabled_flag,
  output logic            watchdog_config_fault,
  output logic            lin_overcurrent_flag,
  output logic            lin_overtemp_flag,
  output logic            lin_tx_enable,
  output logic            lin_pullup_on,
  output logic            lin_alt_wake_threshold,
  output logic [1:0]      lin_slew_out,
  output logic            bus_wake_flag,
  output logic            irq_n
);
  import sbw_pkg::*;

  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    sbw_mode_e     mode;
    logic [31:0]   cnt;
    logic [31:0]   lp_cnt;
    logic [7:0]    rstf;
    logic          cs_prev;
    logic          wake_ref;
    logic          wd_off;
    logic          wd_fault;
    logic          hs_off;
    logic          hs_ot_lat;
    logic          hs_irq;
    logic [1:0]    hs_on;
    logic [1:0]    ol;
    logic [1:0]    cl;
    logic          lin_oc;
    logic          lin_ot;
    logic          lin_txoff;
    logic          lin_irq;
    logic          wake_irq;
    logic          bus_wake;
    logic          tx_en;
    logic          pull_on;
    logic [1:0]    slew;
    logic          rst_n;
    logic          irq_n;
  } sbw_ctrl_s;

  sbw_ctrl_s   s_q, s_d;
  sbw_wake_if  wk ();
  logic [NP-1:0] pins;

  assign pins = {hs_current_limit, hs_open_load, lin_bus_dominant, lin_overtemp,
                 lin_overcurrent, supply_overvoltage, hs_overtemp, watchdog_config_pin_res,
                 watchdog_config_pin_gnd, txd, direct_pwm_input, wake_input_pin, ext_rst_n, cs_n};

  assign wk.en      = (s_q.mode == SBW_STOP) || (s_q.mode == SBW_SLEEP);
  assign wk.bus_dom = s_q.s2[P_BUSDOM];

  sbw_bus_wake #(
    .FILT_CYC (BUS_WAKE_CYC)
  ) u_bus_wake (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wk      (wk)
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    logic        xrst;
    logic        lowp;
    logic        cyclic;
    logic        forced;
    logic        tick;
    logic        wake_lvl;
    logic        hs_trip;
    logic        wake;
    logic        quiet_wake;
    logic [31:0] wd_per;
    logic [31:0] lp_per;
    logic        svc;
    xrst       = 1'b0;
    lowp       = 1'b0;
    cyclic     = 1'b0;
    forced     = 1'b0;
    tick       = 1'b0;
    wake_lvl   = 1'b0;
    hs_trip    = 1'b0;
    wake       = 1'b0;
    quiet_wake = 1'b0;
    wd_per     = 32'h0;
    lp_per     = 32'h0;
    svc        = 1'b0;
    s_d        = s_q;
    s_d.s1     = pins;
    s_d.s2     = s_q.s1;

    // External reset glitch filter.
    if (s_q.s2[P_XRST]) begin
      s_d.rstf = 8'h0;
    end else if (s_q.rstf != RSTF_CYC) begin
      s_d.rstf = s_q.rstf + 8'h1;
    end
    xrst = (s_q.rstf == RSTF_CYC);

    lowp     = (s_q.mode == SBW_STOP) || (s_q.mode == SBW_SLEEP);
    cyclic   = timer_function_select && (|high_side_enable_bit);
    forced   = timer_function_select && !cyclic;
    lp_per   = sbw_shift(32'(LP_BASE_CYC), low_power_period_field);
    wd_per   = sbw_shift(s_q.wd_fault ? 32'(WD_INT_CYC) : 32'(WD_EXT_CYC), wd_prescale);
    wake_lvl = s_q.s2[P_WAKE];
    svc      = mode_wr && (mode_select_field == CMD_NORMAL);

    // Low-power timer and wake sources.
    s_d.cs_prev = s_q.s2[P_CS];
    if (lowp) begin
      tick = timer_function_select && (s_q.lp_cnt >= lp_per - 32'h1);
      s_d.lp_cnt = tick ? 32'h0 : s_q.lp_cnt + 32'h1;
      if (tick && forced) begin
        wake = 1'b1;
      end
      if (tick && cyclic && (wake_lvl != s_q.wake_ref)) begin
        wake = 1'b1;
      end
      if (wake_input_enable && !cyclic && (wake_lvl != s_q.wake_ref)) begin
        wake = 1'b1;
      end
      if (wk.wake) begin
        wake         = 1'b1;
      end
      if (s_q.mode == SBW_STOP) begin
        quiet_wake = (s_q.s2[P_CS] && !s_q.cs_prev) || xrst;
      end
    end else begin
      s_d.lp_cnt   = 32'h0;
      s_d.wake_ref = wake_lvl;
    end

    // Operating mode sequencer.
    s_d.cnt = s_q.cnt + 32'h1;
    unique case (s_q.mode)
      SBW_RESET: begin
        if (xrst) begin
          s_d.cnt = 32'h0;
        end else if (s_q.cnt >= 32'(RST_CYC) - 32'h1) begin
          s_d.wd_off   = s_q.s2[P_GND];
          s_d.wd_fault = !s_q.s2[P_GND] && !s_q.s2[P_RES];
          s_d.mode     = s_q.s2[P_GND] ? SBW_NORMAL : SBW_NREQ;
          s_d.cnt      = 32'h0;
        end
      end
      SBW_NREQ: begin
        if (xrst || s_q.cnt >= 32'(NREQ_CYC) - 32'h1) begin
          s_d.mode = SBW_RESET;
          s_d.cnt  = 32'h0;
        end else if (svc) begin
          s_d.mode = SBW_NORMAL;
          s_d.cnt  = 32'h0;
        end
      end
      SBW_NORMAL: begin
        if (xrst) begin
          s_d.mode = SBW_RESET;
          s_d.cnt  = 32'h0;
        end else if (!s_q.wd_off && svc && s_q.cnt < (wd_per >> 1)) begin
          s_d.mode = SBW_RESET;
          s_d.cnt  = 32'h0;
        end else if (!s_q.wd_off && s_q.cnt >= wd_per - 32'h1) begin
          s_d.mode = SBW_RESET;
          s_d.cnt  = 32'h0;
        end else if (svc) begin
          s_d.cnt = 32'h0;
        end else if (mode_wr && mode_select_field == CMD_STOP) begin
          s_d.mode = SBW_STOP;
        end else if (mode_wr && mode_select_field == CMD_SLEEP) begin
          s_d.mode = SBW_SLEEP;
        end
      end
      SBW_STOP: begin
        s_d.cnt = 32'h0;
        if (wake || quiet_wake) begin
          s_d.mode     = s_q.wd_off ? SBW_NORMAL : SBW_NREQ;
        end
      end
      SBW_SLEEP: begin
        s_d.cnt = 32'h0;
        if (wake) begin
          s_d.mode = SBW_RESET;
        end
      end
    endcase
    s_d.rst_n = (s_d.mode != SBW_RESET);

    // High-side switches.
    hs_trip = s_q.s2[P_HSOT] || (overvoltage_shutdown_enable && s_q.s2[P_OV]);
    if (hs_trip) begin
      s_d.hs_off = 1'b1;
    end else if (hs_ctrl_wr) begin
      s_d.hs_off = 1'b0;
    end
    if (s_q.s2[P_HSOT]) begin
      s_d.hs_ot_lat = 1'b1;
    end else if (hs_ctrl_wr) begin
      s_d.hs_ot_lat = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      s_d.hs_on[i] = high_side_enable_bit[i]
                     && (!switch_pwm_select[i] || s_q.s2[P_PWM])
                     && !hs_trip && !s_q.hs_off
                     && ((s_q.mode == SBW_NREQ) || (s_q.mode == SBW_NORMAL)
                         || (lowp && cyclic && tick));
      s_d.ol[i] = s_q.s2[P_OL+i] || s_q.hs_ot_lat;
      s_d.cl[i] = s_q.s2[P_CL+i] || s_q.hs_ot_lat;
    end

    // Bus transceiver protection.
    if (s_q.s2[P_LOT]) begin
      s_d.lin_txoff = 1'b1;
    end else if (s_q.s2[P_TXD]) begin
      s_d.lin_txoff = 1'b0;
    end
    s_d.tx_en   = (s_q.mode == SBW_NORMAL) && !s_d.lin_txoff;
    s_d.pull_on = !lowp || lin_pullup_enable;
    s_d.slew    = lin_slew_select;

    // Sticky sources, acknowledged by a status read; a new event wins.
    if (status_read_ack) begin
      s_d.hs_irq   = 1'b0;
      s_d.lin_oc   = 1'b0;
      s_d.lin_ot   = 1'b0;
      s_d.lin_irq  = 1'b0;
      s_d.wake_irq = 1'b0;
      s_d.bus_wake = 1'b0;
    end
    if (s_q.s2[P_HSOT]) begin
      s_d.hs_irq = 1'b1;
    end
    if (s_q.s2[P_LOC]) begin
      s_d.lin_oc  = 1'b1;
      s_d.lin_irq = 1'b1;
    end
    if (s_q.s2[P_LOT]) begin
      s_d.lin_ot  = 1'b1;
      s_d.lin_irq = 1'b1;
    end
    if (wk.wake) begin
      s_d.bus_wake = 1'b1;
    end
    if (lowp && wake && s_q.mode == SBW_STOP) begin
      s_d.wake_irq = 1'b1;
    end
    s_d.irq_n = !(((s_d.hs_irq && high_side_irq_mask)
                   || (s_d.lin_irq && lin_irq_mask)
                   || s_d.wake_irq)
                  && (s_d.mode != SBW_SLEEP) && (s_d.mode != SBW_RESET));
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.s1      <= PIN_IDLE;
      s_q.s2      <= PIN_IDLE;
      s_q.cs_prev <= 1'b1;
      s_q.mode    <= SBW_RESET;
      s_q.pull_on <= 1'b1;
      s_q.slew    <= SLEW_20K;
      s_q.irq_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign mode_state                = s_q.mode;
  assign mcu_rst_n                 = s_q.rst_n;
  assign hs_on                     = s_q.hs_on;
  assign switch_open_load_flag     = s_q.ol;
  assign switch_current_limit_flag = s_q.cl;
  assign hs_irq_source             = s_q.hs_irq;
  assign watchdog_disabled_flag    = s_q.wd_off;
  assign watchdog_config_fault     = s_q.wd_fault;
  assign lin_overcurrent_flag      = s_q.lin_oc;
  assign lin_overtemp_flag         = s_q.lin_ot;
  assign lin_tx_enable             = s_q.tx_en;
  assign lin_pullup_on             = s_q.pull_on;
  assign lin_alt_wake_threshold    = !s_q.pull_on;
  assign lin_slew_out              = s_q.slew;
  assign bus_wake_flag             = s_q.bus_wake;
  assign irq_n                     = s_q.irq_n;

endmodule : sbw_ctrl

// ### test/sbw_host_model.sv
`timescale 1ns/1ns
module sbw_host_model (
  input  wire logic clk,
  output logic      mode_wr,
  output logic [1:0] mode_select_field,
  output logic      hs_ctrl_wr,
  output logic      status_read_ack
);
  import sbw_pkg::*;
  // ************************************************************
  // Host writes and reads, each a one-cycle strobe.
  // ************************************************************
  initial begin
    {mode_wr, hs_ctrl_wr, status_read_ack} = 3'h0;
    mode_select_field = CMD_NORMAL;
  end
  // A mode write is also the only way to service the watchdog.
  task automatic mode_cmd(input logic [1:0] code);
    @(negedge clk);
    mode_select_field = code;
    mode_wr = 1'b1;
    @(negedge clk);
    mode_wr = 1'b0;
  endtask : mode_cmd
  // Kind 0 writes the switch control, kind 1 reads status to acknowledge.
  task automatic strobe(input logic kind);
    @(negedge clk);
    if (kind) status_read_ack = 1'b1;
    else hs_ctrl_wr = 1'b1;
    @(negedge clk);
    {hs_ctrl_wr, status_read_ack} = 2'h0;
  endtask : strobe
endmodule : sbw_host_model

// ### test/sbw_props.sv
`timescale 1ns/1ns
module sbw_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       hs_overtemp,
  input wire logic       lin_overtemp,
  input wire logic       lin_irq_mask,
  input wire logic       lin_pullup_enable,
  input wire logic [1:0] lin_slew_select,
  input wire logic       mode_wr,
  input wire logic [1:0] mode_select_field,
  input wire logic       status_read_ack,
  input wire logic [4:0] mode_state,
  input wire logic       mcu_rst_n,
  input wire logic [1:0] hs_on,
  input wire logic [1:0] switch_open_load_flag,
  input wire logic [1:0] switch_current_limit_flag,
  input wire logic       watchdog_disabled_flag,
  input wire logic       lin_overcurrent_flag,
  input wire logic       lin_tx_enable,
  input wire logic       lin_pullup_on,
  input wire logic [1:0] lin_slew_out,
  input wire logic       bus_wake_flag,
  input wire logic       irq_n
);
  import sbw_pkg::*;
  // ************************************************************
  // Port relations.
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  hs_heat_off_a: assert property (hs_overtemp [*5] |-> hs_on == 2'h0)
    else $error("switch on during over-temperature");
  hs_heat_flags_a: assert property (hs_overtemp [*5] |->
    switch_open_load_flag == 2'h3 && switch_current_limit_flag == 2'h3)
    else $error("switch flags not all set on over-temperature");
  lin_heat_off_a: assert property (lin_overtemp [*5] |-> !lin_tx_enable)
    else $error("transmitter on during over-temperature");
  lin_oc_irq_a: assert property ((lin_overcurrent_flag && lin_irq_mask &&
    mode_state == 5'h04 && !status_read_ack) [*3] |-> !irq_n)
    else $error("over-current interrupt missing");
  irq_hold_a: assert property ($rose(irq_n) && mode_state != 5'h01 &&
    mode_state != 5'h10 |-> $past(status_read_ack) || $past(status_read_ack, 2))
    else $error("interrupt released without acknowledge");
  nreq_leave_a: assert property (mode_wr && mode_select_field == CMD_NORMAL &&
    mode_state == 5'h02 |=> mode_state == 5'h04)
    else $error("service did not leave normal request");
  wd_off_a: assert property (watchdog_disabled_flag [*3] |-> mode_state != 5'h02)
    else $error("normal request with watchdog disabled");
  rst_low_a: assert property (mode_state == 5'h01 |-> !mcu_rst_n)
    else $error("controller reset not driven in reset mode");
  slew_follow_a: assert property ($stable(lin_slew_select) [*3] |->
    lin_slew_out == lin_slew_select)
    else $error("slew output differs from select");
  pullup_drop_a: assert property ((mode_state == 5'h08 && !lin_pullup_enable) [*3] |->
    !lin_pullup_on)
    else $error("bus pull-up kept in stop");
  stop_c: cover property (mode_state == 5'h08);
  bus_wake_c: cover property ($rose(bus_wake_flag));
  reset_mode_c: cover property ($fell(mcu_rst_n));
endmodule : sbw_props
bind sbw_ctrl sbw_props sbw_props_i (.*);

// ### test/sbw_ctrl_bench.sv
`timescale 1ns/1ns
module sbw_ctrl_bench;
  import sbw_pkg::*;
  // ************************************************************
  // Sequences of host calls and pin changes against expected values.
  // ************************************************************
  logic clk, sys_rst, cs_n, ext_rst_n, wake_input_pin, direct_pwm_input, txd;
  logic watchdog_config_pin_gnd, watchdog_config_pin_res, hs_overtemp, supply_overvoltage, lin_overcurrent;
  logic lin_overtemp, lin_bus_dominant, timer_function_select, wake_input_enable;
  logic overvoltage_shutdown_enable, lin_pullup_enable, high_side_irq_mask, lin_irq_mask;
  logic mode_wr, hs_ctrl_wr, status_read_ack, mcu_rst_n, hs_irq_source, irq_n;
  logic watchdog_disabled_flag, watchdog_config_fault, lin_overcurrent_flag;
  logic lin_overtemp_flag, lin_tx_enable, lin_pullup_on, lin_alt_wake_threshold, bus_wake_flag;
  logic [1:0] hs_open_load, hs_current_limit, mode_select_field, high_side_enable_bit, hs_on;
  logic [1:0] switch_pwm_select, lin_slew_select, switch_open_load_flag;
  logic [1:0] switch_current_limit_flag, lin_slew_out;
  logic [2:0] low_power_period_field, wd_prescale;
  logic [4:0] mode_state;
  int bad_count;
  int checks_done;
  int n;
  logic [6:0] hs_tab [5] = '{7'b0100001, 7'b1110001, 7'b1110111, 7'b1011000, 7'b0011100};
  logic [1:0] slews [3] = '{SLEW_10K4, SLEW_FAST, SLEW_20K};

  sbw_ctrl #(.WD_INT_CYC(2000), .WD_EXT_CYC(1000), .NREQ_CYC(3000), .RST_CYC(50),
    .BUS_WAKE_CYC(20), .LP_BASE_CYC(100)) sbw_ctrl_i (.*);
  sbw_host_model sbw_host_model_i (.*);

  always #5 clk = ~clk;

  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wait_mode(input logic [4:0] m, input int lim);
    for (int i = 0; i < lim && mode_state !== m; i++) @(negedge clk);
    chk(mode_state, m);
  endtask : wait_mode
  task automatic cmd(input logic [1:0] c);
    sbw_host_model_i.mode_cmd(c);
  endtask : cmd
  task automatic wr();
    sbw_host_model_i.strobe(1'b0);
    cyc(2);
  endtask : wr
  task automatic ack();
    sbw_host_model_i.strobe(1'b1);
    cyc(3);
  endtask : ack
  task automatic do_reset(input logic [4:0] m);
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    wait_mode(m, 200);
  endtask : do_reset
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #600000;
    bad_count++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {cs_n, ext_rst_n, txd, watchdog_config_pin_gnd, lin_pullup_enable} = 5'h1F;
    {wake_input_pin, direct_pwm_input, watchdog_config_pin_res, hs_overtemp, supply_overvoltage} = 5'h00;
    {lin_overcurrent, lin_overtemp, lin_bus_dominant, timer_function_select} = 4'h0;
    {wake_input_enable, overvoltage_shutdown_enable, high_side_irq_mask, lin_irq_mask} = 4'h0;
    {hs_open_load, hs_current_limit, high_side_enable_bit, switch_pwm_select} = 8'h00;
    {low_power_period_field, wd_prescale, lin_slew_select} = 8'h00;
    do_reset(5'h04);
    chk({watchdog_disabled_flag, mcu_rst_n, irq_n, lin_slew_out}, 5'b11100);
    cyc(1500);
    chk(mode_state, 5'h04);
    $display("reset and grounded strap test done");
    foreach (hs_tab[k]) begin
      {high_side_enable_bit, switch_pwm_select, direct_pwm_input} = hs_tab[k][6:2];
      wr();
      cyc(4);
      chk({3'h0, hs_on}, {3'h0, hs_tab[k][1:0]});
    end
    {high_side_enable_bit, switch_pwm_select, hs_open_load, hs_current_limit} = 8'hC9;
    wr();
    cyc(4);
    chk({hs_on, switch_open_load_flag, 1'b0}, 5'b11100);
    chk({3'h0, switch_current_limit_flag}, 5'h01);
    {hs_open_load, hs_current_limit, hs_overtemp} = 5'h01;
    cyc(6);
    chk({hs_on, switch_open_load_flag, irq_n}, 5'b00111);
    chk({hs_irq_source, switch_current_limit_flag, 2'h0}, 5'b11100);
    wr();
    chk({3'h0, hs_on}, 5'h00);
    high_side_irq_mask = 1'b1;
    cyc(3);
    chk({4'h0, irq_n}, 5'h00);
    hs_overtemp = 1'b0;
    cyc(5);
    chk({3'h0, hs_on}, 5'h00);
    ack();
    chk({3'h0, irq_n, hs_irq_source}, 5'h02);
    wr();
    chk({3'h0, hs_on}, 5'h03);
    supply_overvoltage = 1'b1;
    cyc(5);
    chk({3'h0, hs_on}, 5'h03);
    overvoltage_shutdown_enable = 1'b1;
    cyc(5);
    wr();
    chk({3'h0, hs_on}, 5'h00);
    supply_overvoltage = 1'b0;
    cyc(5);
    chk({3'h0, hs_on}, 5'h00);
    wr();
    chk({3'h0, hs_on}, 5'h03);
    $display("switch test done");
    lin_overcurrent = 1'b1;
    cyc(5);
    lin_overcurrent = 1'b0;
    chk({lin_overcurrent_flag, lin_tx_enable, irq_n, 2'h0}, 5'b11100);
    lin_irq_mask = 1'b1;
    cyc(3);
    chk({4'h0, irq_n}, 5'h00);
    ack();
    chk({3'h0, lin_overcurrent_flag, irq_n}, 5'h01);
    {txd, lin_overtemp} = 2'b01;
    cyc(5);
    chk({lin_overtemp_flag, lin_tx_enable, irq_n, 2'h0}, 5'b10000);
    lin_overtemp = 1'b0;
    cyc(5);
    chk({4'h0, lin_tx_enable}, 5'h00);
    txd = 1'b1;
    cyc(5);
    chk({4'h0, lin_tx_enable}, 5'h01);
    ack();
    foreach (slews[k]) begin
      lin_slew_select = slews[k];
      cyc(4);
      chk({3'h0, lin_slew_out}, {3'h0, slews[k]});
    end
    $display("bus driver test done");
    lin_pullup_enable = 1'b0;
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_STOP);
      cyc(3);
      chk({lin_pullup_on, lin_alt_wake_threshold, mode_state[4:2]}, 5'b01010);
      case (k)
        1: begin cs_n = 1'b0; cyc(5); cs_n = 1'b1; end
        2: begin ext_rst_n = 1'b0; cyc(110); ext_rst_n = 1'b1; end
        default: begin lin_bus_dominant = 1'b1; cyc(k == 3 ? 40 : 10); lin_bus_dominant = 1'b0; end
      endcase
      if (k == 0) begin
        cyc(100);
        chk(mode_state, 5'h08);
      end else begin
        wait_mode(5'h04, 400);
      end
      cyc(3);
      chk({bus_wake_flag, irq_n, 3'h0}, k == 3 ? 5'b10000 : 5'b01000);
      ack();
    end
    $display("stop wake test done");
    {wake_input_enable, high_side_enable_bit, lin_pullup_enable} = 4'h9;
    wr();
    cmd(CMD_SLEEP);
    cyc(3);
    cs_n = 1'b0;
    cyc(5);
    cs_n = 1'b1;
    cyc(50);
    chk({lin_pullup_on, mode_state[4:1]}, 5'h18);
    wake_input_pin = 1'b1;
    wait_mode(5'h01, 100);
    wait_mode(5'h04, 200);
    {wake_input_enable, timer_function_select, low_power_period_field} = 5'h9;
    cmd(CMD_STOP);
    cyc(150);
    chk(mode_state, 5'h08);
    wait_mode(5'h04, 2000);
    ack();
    high_side_enable_bit = 2'h1;
    wr();
    cmd(CMD_STOP);
    cyc(600);
    chk(mode_state, 5'h08);
    wake_input_pin = 1'b0;
    wait_mode(5'h04, 300);
    ack();
    $display("sleep and timer wake test done");
    {watchdog_config_pin_gnd, watchdog_config_pin_res, timer_function_select} = 3'h2;
    do_reset(5'h02);
    chk({3'h0, watchdog_disabled_flag, watchdog_config_fault}, 5'h00);
    n = 0;
    while (mode_state === 5'h02 && n < 4000) begin
      cyc(1);
      n++;
    end
    chk({mode_state[4:1], n > 2950}, 5'h01);
    wait_mode(5'h02, 200);
    cmd(CMD_NORMAL);
    cmd(CMD_NORMAL);
    cyc(2);
    chk(mode_state, 5'h01);
    wait_mode(5'h02, 200);
    cmd(CMD_NORMAL);
    cyc(700);
    cmd(CMD_NORMAL);
    cyc(3);
    chk(mode_state, 5'h04);
    wd_prescale = 3'h1;
    cyc(700);
    cmd(CMD_NORMAL);
    cyc(2);
    chk(mode_state, 5'h01);
    wait_mode(5'h02, 200);
    cmd(CMD_NORMAL);
    wait_mode(5'h01, 2100);
    {watchdog_config_pin_res, wd_prescale} = 4'h0;
    do_reset(5'h02);
    chk({4'h0, watchdog_config_fault}, 5'h01);
    cmd(CMD_NORMAL);
    cyc(700);
    cmd(CMD_NORMAL);
    cyc(2);
    chk(mode_state, 5'h01);
    $display("watchdog test done");
    end_of_test();
  end
endmodule : sbw_ctrl_bench
